// ===== remap_lock_and_input_select.sv
/*
  Remap lock, one-session lock, shadow monitoring and the pin-select
  register file (input and output selectors) behind a plain register port.
  Assumes a single clock; the bus master never asserts both strobes at once.
*/
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "remap_lock_params.svh"

// Function
// (RQ1) Shadow every selector register and flag a mismatch reset on unexpected change.
// (RQ2) With one-session set, lock bit cannot be cleared once set.
// (RQ3) While locked, selectors stay unwritable; once the one-session lock engages, the unlock sequence does nothing.
// (RQ4) After one-session lock engages, only device reset unlocks remapping.
// (RQ5) One-session bit resets set; cleared it allows unlimited unlock sessions.
// (RQ6) Implemented pins depend on package: 28, 31 or 32 I/O pins.
// (RQ7) Reset loads input selectors with all ones, output selectors with zeros.
// (RQ8) All-ones input selector ties the input low even without that pin.
// (RQ9) Lock bit resets unlocked so selectors are writable straight after reset.
// (RQ10) Software should set the lock after configuring the selectors.
// (RQ11) Software issues the key sequence as back-to-back writes.
// (RQ12) Routing never changes pin direction nor enables the peripheral.
// (RQ13) Routing never overrides an analog pin function.
// (RQ14) Software should park unused inputs and give unused pins the null output.
// (RQ15) Twenty-one input-select and sixteen output-select registers exist.
// (RQ16) Selector values change only while the lock bit is zero.
// (RQ17) First input register holds the interrupt 1 selector in bits 13 to 8.
// (RQ18) Second input register: interrupt 3 in bits 13-8, interrupt 2 in 5-0.
// (RQ19) Lock bit changes need key writes 46h then 57h, then the lock write.
// (RQ20) Locked selector writes complete silently and change nothing.
// (RQ21) Input selector above 43 is invalid and leaves the input unmapped.
// (RQ22) Output code zero is the null function and the reset value.
// (RQ23) Shadows follow every accepted write so only upsets cause mismatch.

module remap_lock_and_input_select #(
	parameter int PKG_PINS  = `PKG_PIN_COUNT,
	parameter int IN_REGS   = `IN_REG_COUNT,
	parameter int OUT_REGS  = `OUT_REG_COUNT
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic [9:0]                  addr,
	input  wire logic [15:0]                 wr_data,
	input  wire logic                        wr_en,
	input  wire logic                        rd_en,
	output logic      [15:0]                 rd_data,
	output remap_lock_pkg::irq_route_t       ext_irq1_route,
	output remap_lock_pkg::irq_route_t       ext_irq2_route,
	output remap_lock_pkg::irq_route_t       ext_irq3_route,
	output logic                             remap_locked,
	output logic                             config_mismatch_reset
);

	remap_lock_pkg::unlock_state_t key_state;
	remap_lock_pkg::unlock_state_t next_key_state;

	logic                          remap_lock_bit;
	logic                          one_way_engaged;
	logic [15:0]                   config_word_two;
	logic [IN_REGS-1:0][15:0]      input_select_regs;
	logic [IN_REGS-1:0][15:0]      input_shadow;
	logic [OUT_REGS-1:0][15:0]     output_select_regs;
	logic [OUT_REGS-1:0][15:0]     output_shadow;
	logic                          mismatch;
	logic                          irq1_mapped;
	logic                          irq2_mapped;
	logic                          irq3_mapped;

	// Address decode
	wire osc_hit    = (addr == `OSC_CTRL_ADDR);
	wire cfg_hit    = (addr == `CFG_WORD2_ADDR);
	wire status_hit = (addr == `STATUS_ADDR);
	wire [4:0] in_idx  = addr[6:2];
	wire [3:0] out_idx = addr[5:2];
	wire in_hit  = (addr[9:8] == `IN_REGION) && (addr[1:0] == 2'h0)
		&& ({2'h0, addr[7:2]} < 8'(IN_REGS));
	wire out_hit = (addr[9:8] == `OUT_REGION) && (addr[1:0] == 2'h0)
		&& ({2'h0, addr[7:2]} < 8'(OUT_REGS));
	wire osc_wr  = wr_en && osc_hit;

	// Key sequence; an engaged one-way lock blocks the first key write
	wire key1_seen = osc_wr && (wr_data[7:0] == `UNLOCK_KEY1) && !one_way_engaged; // see (RQ3) see (RQ4)
	wire key2_seen = osc_wr && (wr_data[7:0] == `UNLOCK_KEY2); // see (RQ19)
	wire lock_wr   = osc_wr && (key_state == remap_lock_pkg::KEY_ARMED);

	// Lock only moves on the armed write; the engaged flag forbids a clear
	wire next_lock    = lock_wr ? (wr_data[`LOCK_BIT] | one_way_engaged) : remap_lock_bit; // see (RQ2) see (RQ19)
	wire next_engaged = one_way_engaged
		| (remap_lock_bit & config_word_two[`ONE_SESSION_BIT]); // see (RQ2) see (RQ5)

	// Selector writes are swallowed while locked, with no error
	wire sel_wr_ok = wr_en && !remap_lock_bit; // see (RQ16) see (RQ20) see (RQ3)
	wire in_wr     = sel_wr_ok && in_hit;
	wire out_wr    = sel_wr_ok && out_hit;
	wire [15:0] in_wr_val  = wr_data & remap_lock_pkg::in_mask(in_idx); // see (RQ17) see (RQ18)
	wire [15:0] out_wr_val = wr_data & remap_lock_pkg::out_mask(PKG_PINS, out_idx); // see (RQ6)

	// Status word for software
	wire [15:0] status_word = {11'h000, mismatch, one_way_engaged, key_state, remap_lock_bit};

	// Read mux; unmapped addresses answer zero
	wire [15:0] next_rd_data =
		!rd_en      ? 16'h0000 :
		osc_hit     ? {9'h000, remap_lock_bit, 6'h00} :
		cfg_hit     ? config_word_two :
		status_hit  ? status_word :
		in_hit      ? input_select_regs[in_idx] :
		out_hit     ? output_select_regs[out_idx] :
		16'h0000;

	// Key sequence state; any other write breaks the back-to-back run
	always_comb
	begin
		next_key_state = remap_lock_pkg::KEY_IDLE;
		case (key_state)
			remap_lock_pkg::KEY_IDLE:
				next_key_state = key1_seen ? remap_lock_pkg::KEY_FIRST : remap_lock_pkg::KEY_IDLE;
			remap_lock_pkg::KEY_FIRST:
				next_key_state = key2_seen ? remap_lock_pkg::KEY_ARMED : remap_lock_pkg::KEY_IDLE; // see (RQ11)
			remap_lock_pkg::KEY_ARMED:
				next_key_state = wr_en ? remap_lock_pkg::KEY_IDLE : remap_lock_pkg::KEY_ARMED;
			default:
				next_key_state = remap_lock_pkg::KEY_IDLE;
		endcase
		if (!wr_en)
			next_key_state = key_state;
	end

	// Lock control flops; reset comes up unlocked
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			key_state       <= remap_lock_pkg::KEY_IDLE;
			remap_lock_bit  <= 1'b0; // see (RQ9)
			one_way_engaged <= 1'b0; // see (RQ4)
		end
		else
		begin
			key_state       <= next_key_state;
			remap_lock_bit  <= next_lock;
			one_way_engaged <= next_engaged;
		end
	end

	// Session-mode bit, only changeable while the map is unlocked
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			config_word_two <= `CFG_WORD2_RESET; // see (RQ5)
		else if (sel_wr_ok && cfg_hit)
			config_word_two <= wr_data & (16'h0001 << `ONE_SESSION_BIT);
	end

	// Input selectors and shadows; reset ties every input low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < IN_REGS; i++)
			begin
				input_select_regs[i] <= `IN_SEL_RESET & remap_lock_pkg::in_mask(5'(i)); // see (RQ7) see (RQ15)
				input_shadow[i]      <= `IN_SEL_RESET & remap_lock_pkg::in_mask(5'(i));
			end
		end
		else if (in_wr)
		begin
			input_select_regs[in_idx] <= in_wr_val;
			input_shadow[in_idx]      <= in_wr_val; // see (RQ23)
		end
	end

	// Output selectors and shadows; reset gives every pin the null function
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			output_select_regs <= {OUT_REGS{`OUT_SEL_RESET}}; // see (RQ22) see (RQ7) see (RQ15)
			output_shadow      <= {OUT_REGS{`OUT_SEL_RESET}};
		end
		else if (out_wr)
		begin
			output_select_regs[out_idx] <= out_wr_val;
			output_shadow[out_idx]      <= out_wr_val; // see (RQ23)
		end
	end

	// Interrupt selector validity checks
	selector_check #(
		.PKG_PINS (PKG_PINS)
	) u_check1 (
		.sel    (input_select_regs[0][13:8]),
		.mapped (irq1_mapped)
	);

	selector_check #(
		.PKG_PINS (PKG_PINS)
	) u_check2 (
		.sel    (input_select_regs[1][5:0]),
		.mapped (irq2_mapped)
	);

	selector_check #(
		.PKG_PINS (PKG_PINS)
	) u_check3 (
		.sel    (input_select_regs[1][13:8]),
		.mapped (irq3_mapped)
	);

	// Upset detector over the whole selector file
	shadow_monitor #(
		.WIDTH ((IN_REGS + OUT_REGS) * 16)
	) u_monitor (
		.clk      (clk),
		.rst_n    (rst_n),
		.live     ({input_select_regs, output_select_regs}),
		.shadow   ({input_shadow, output_shadow}),
		.mismatch (mismatch)
	);

	// Registered outputs; routes carry only selection, never pin direction,
	// peripheral enable or analog overrides, which stay with the pad logic
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_data               <= 16'h0000;
			ext_irq1_route        <= '{sel: `SEL_TIE_LOW, mapped: 1'b0};
			ext_irq2_route        <= '{sel: `SEL_TIE_LOW, mapped: 1'b0};
			ext_irq3_route        <= '{sel: `SEL_TIE_LOW, mapped: 1'b0};
			remap_locked          <= 1'b0;
			config_mismatch_reset <= 1'b0;
		end
		else
		begin
			rd_data               <= next_rd_data;
			ext_irq1_route        <= '{sel: input_select_regs[0][13:8], mapped: irq1_mapped}; // see (RQ17) see (RQ12)
			ext_irq2_route        <= '{sel: input_select_regs[1][5:0], mapped: irq2_mapped}; // see (RQ18) see (RQ13)
			ext_irq3_route        <= '{sel: input_select_regs[1][13:8], mapped: irq3_mapped}; // see (RQ18)
			remap_locked          <= remap_lock_bit;
			config_mismatch_reset <= mismatch; // see (RQ1)
		end
	end

endmodule

`default_nettype wire

// ===== remap_lock_params.svh
/*
  Constants for the remap lock and pin-select block: register offsets,
  field positions, reset values and key codes.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef REMAP_LOCK_PARAMS_SVH
`define REMAP_LOCK_PARAMS_SVH

// Byte addresses, region codes and register counts for the 10-bit register port
`define OSC_CTRL_ADDR      10'h000
`define CFG_WORD2_ADDR     10'h004
`define STATUS_ADDR        10'h008
`define IN_REGION          2'h1
`define OUT_REGION         2'h2
`define IN_REG_COUNT       21
`define OUT_REG_COUNT      16
`define PKG_PIN_COUNT      100

// Lock control fields
`define UNLOCK_KEY1        8'h46
`define UNLOCK_KEY2        8'h57
`define LOCK_BIT           6
`define ONE_SESSION_BIT    4
`define CFG_WORD2_RESET    16'h0010

// Selector fields
`define SEL_HI_MASK        16'h3f00
`define SEL_LO_MASK        16'h003f
`define IN_SEL_RESET       16'h3f3f
`define OUT_SEL_RESET      16'h0000
`define SEL_MAX_VALID      6'h2b
`define SEL_TIE_LOW        6'h3f
`define RP_LIMIT           6'h20

`endif

// ===== remap_lock_pkg.sv
/*
  Types and shared decode functions for the remap lock block.
  Assumes remap_lock_params.svh is on the include path.
*/
`include "remap_lock_params.svh"

package remap_lock_pkg;

	typedef enum logic [1:0]
	{
		KEY_IDLE  = 2'b00,
		KEY_FIRST = 2'b01,
		KEY_ARMED = 2'b11
	} unlock_state_t;

	typedef struct packed
	{
		logic [5:0] sel;
		logic       mapped;
	} irq_route_t;

	// Pin existence per package; selectors above the valid range never exist
	function automatic logic pin_present(input int pins, input logic [5:0] n);
		logic ok;
		ok = (n <= `SEL_MAX_VALID);
		if (pins == 64)
			ok = ok && !(n == 6'h05 || n == 6'h0f || n == 6'h1e || n == 6'h1f)
				&& (n < `RP_LIMIT || n == 6'h25);
		else if (pins == 80)
			ok = ok && !(n == 6'h1f || n == 6'h20 || n == 6'h27 || n == 6'h29);
		return ok;
	endfunction

	// Implemented bits of an input-select register
	function automatic logic [15:0] in_mask(input logic [4:0] idx);
		return (idx == 5'h00) ? `SEL_HI_MASK : (`SEL_HI_MASK | `SEL_LO_MASK);
	endfunction

	// Output fields of absent pins are unimplemented
	function automatic logic [15:0] out_mask(input int pins, input logic [3:0] idx);
		logic [15:0] m;
		m = 16'h0000;
		if (pin_present(pins, {1'b0, idx, 1'b0}))
			m = m | `SEL_LO_MASK;
		if (pin_present(pins, {1'b0, idx, 1'b1}))
			m = m | `SEL_HI_MASK;
		return m;
	endfunction

endpackage

// ===== selector_check.sv
/*
  Decides whether an input selector names a real pin of this package.
  Assumes the selector comes from a register on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "remap_lock_params.svh"

module selector_check #(
	parameter int PKG_PINS = `PKG_PIN_COUNT
) (
	input  wire logic [5:0] sel,
	output logic            mapped
);

	// Tie-low code and absent pins leave the peripheral input unmapped
	assign mapped = remap_lock_pkg::pin_present(PKG_PINS, sel); // see (RQ21) see (RQ8) see (RQ6)

endmodule

`default_nettype wire

// ===== shadow_monitor.sv
/*
  Continuous compare of live selector storage against its shadow copy.
  Assumes both vectors are flops on the same clock; the flag is sticky.
*/
`timescale 1ns/100ps
`default_nettype none

module shadow_monitor #(
	parameter int WIDTH = 592
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] live,
	input  wire logic [WIDTH-1:0] shadow,
	output logic                  mismatch
);

	wire differ = (live != shadow);

	// Sticky until reset, so a one-cycle upset is never lost
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mismatch <= 1'b0;
		else
			mismatch <= mismatch | differ; // see (RQ1)
	end

endmodule

`default_nettype wire

// ===== remap_lock_monitor.sv
/*
  Checker for the remap lock block, bound to its top module.
  Assumes one clock, synchronous active-low reset, ports as declared.
*/
`timescale 1ns/100ps
`default_nettype none

module remap_lock_monitor #(
	parameter int PKG_PINS = 100
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [9:0]                 addr,
	input  wire logic [15:0]                wr_data,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	input  wire logic [15:0]                rd_data,
	input  wire remap_lock_pkg::irq_route_t ext_irq1_route,
	input  wire remap_lock_pkg::irq_route_t ext_irq2_route,
	input  wire remap_lock_pkg::irq_route_t ext_irq3_route,
	input  wire logic                       remap_locked,
	input  wire logic                       config_mismatch_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Single-session bit seen from outside; only ever cleared, so it never overclaims
	logic sess;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sess <= 1'b1;
		else if (wr_en && addr == 10'h004 && !remap_locked && !wr_data[4])
			sess <= 1'b0;
	end

	sequence s_keys;
		wr_en && addr == 10'h000 && wr_data[7:0] == 8'h46 ##1 wr_en && addr == 10'h000 && wr_data[7:0] == 8'h57;
	endsequence

	property p_rd_zero; !rd_en |=> rd_data == 16'h0000; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data not idle");
	property p_in0; rd_en && addr == 10'h100 |=> (rd_data & 16'hc0ff) == 16'h0000; endproperty
	a_in0: assert property (p_in0) else $error("input reg 0 unused bits set");
	property p_in1; rd_en && addr == 10'h104 |=> (rd_data & 16'hc0c0) == 16'h0000; endproperty
	a_in1: assert property (p_in1) else $error("input reg 1 unused bits set");
	property p_tie; ext_irq2_route.sel == 6'h3f |-> !ext_irq2_route.mapped; endproperty
	a_tie: assert property (p_tie) else $error("tie-low selector mapped");
	property p_invalid; ext_irq1_route.sel > 6'h2b |-> !ext_irq1_route.mapped; endproperty
	a_invalid: assert property (p_invalid) else $error("invalid selector mapped");
	property p_reset;
		disable iff (1'b0) !rst_n |=> ext_irq3_route.sel == 6'h3f && !remap_locked && !config_mismatch_reset;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_locked_stable; remap_locked && $past(remap_locked) |-> $stable(ext_irq2_route); endproperty
	a_locked_stable: assert property (p_locked_stable) else $error("route moved while locked");
	property p_one_way; sess && remap_locked |=> remap_locked; endproperty
	a_one_way: assert property (p_one_way) else $error("one-session lock released");
	property p_key;
		s_keys ##1 (wr_en && addr == 10'h000 && !(sess && remap_locked)) |-> ##2 remap_locked == $past(wr_data[6], 2);
	endproperty
	a_key: assert property (p_key) else $error("key sequence did not set lock");
	property p_no_mismatch; !config_mismatch_reset; endproperty
	a_no_mismatch: assert property (p_no_mismatch) else $error("mismatch without upset");
endmodule

bind remap_lock_and_input_select remap_lock_monitor #(.PKG_PINS(PKG_PINS)) u_mon (.clk(clk), .rst_n(rst_n),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.ext_irq1_route(ext_irq1_route), .ext_irq2_route(ext_irq2_route), .ext_irq3_route(ext_irq3_route),
	.remap_locked(remap_locked), .config_mismatch_reset(config_mismatch_reset));

`default_nettype wire

// ===== remap_lock_and_input_select_test.sv
/*
  Self-checking bench for the remap lock block, 64-pin package.
  Assumes the checker file is compiled alongside for its bind.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end end

module remap_lock_and_input_select_test;
	logic                       clk = 1'b0;
	logic                       rst_n = 1'b0;
	logic [9:0]                 addr = 10'h000;
	logic [15:0]                wr_data = 16'h0000;
	logic                       wr_en = 1'b0;
	logic                       rd_en = 1'b0;
	logic [15:0]                rd_data;
	remap_lock_pkg::irq_route_t irq1;
	remap_lock_pkg::irq_route_t irq2;
	remap_lock_pkg::irq_route_t irq3;
	logic                       locked;
	logic                       mismatch;
	int                         error_cnt = 0;
	int                         comparisons = 0;
	int                         cycles = 0;

	always #10 clk = ~clk;

	remap_lock_and_input_select #(.PKG_PINS(64)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_irq1_route(irq1), .ext_irq2_route(irq2),
		.ext_irq3_route(irq3), .remap_locked(locked), .config_mismatch_reset(mismatch));

	task automatic print_verdict();
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Strobe stays up so back-to-back key writes need no gap
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
	endtask

	task automatic idle();
		wr_en <= 1'b0;
		@(posedge clk);
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		`CHK("rd_data", e, rd_data)
		@(posedge clk);
	endtask

	// Back-to-back key writes, then the lock write itself
	task automatic key(input logic [15:0] d);
		wr(10'h000, 16'h0046);
		wr(10'h000, 16'h0057);
		wr(10'h000, d);
		idle();
	endtask

	// Levels checked mid-cycle, away from the launching edge
	task automatic outs(input logic [6:0] e1, input logic [6:0] e2, input logic [6:0] e3, input logic el);
		@(negedge clk);
		`CHK("irq1", e1, irq1)
		`CHK("irq2", e2, irq2)
		`CHK("irq3", e3, irq3)
		`CHK("locked", el, locked)
		@(posedge clk);
	endtask

	task automatic t_reset();
		rd(10'h100, 16'h3f00);
		rd(10'h104, 16'h3f3f);
		rd(10'h200, 16'h0000);
		rd(10'h004, 16'h0010);
		rd(10'h000, 16'h0000);
		rd(10'h3fc, 16'h0000);
		outs(7'h7e, 7'h7e, 7'h7e, 1'b0);
	endtask

	task automatic t_route();
		wr(10'h104, 16'hffff);
		idle();
		rd(10'h104, 16'h3f3f);
		wr(10'h104, 16'h2505);
		wr(10'h100, 16'h2c00);
		idle();
		rd(10'h100, 16'h2c00);
		outs(7'h58, 7'h0a, 7'h4b, 1'b0);
		wr(10'h100, 16'h0400);
		wr(10'h208, 16'h3f3f);
		idle();
		rd(10'h208, 16'h003f);
		wr(10'h208, 16'h0000);
		idle();
		rd(10'h208, 16'h0000);
		outs(7'h09, 7'h0a, 7'h4b, 1'b0);
	endtask

	// Default one-session setting: second key attempt must be ignored
	task automatic t_lock();
		key(16'h0040);
		rd(10'h000, 16'h0040);
		wr(10'h100, 16'h1000);
		wr(10'h004, 16'h0000);
		idle();
		rd(10'h100, 16'h0400);
		rd(10'h004, 16'h0010);
		key(16'h0000);
		outs(7'h09, 7'h0a, 7'h4b, 1'b1);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(10'h000, 16'h0000);
		rd(10'h100, 16'h3f00);
	endtask

	task automatic t_multi();
		wr(10'h004, 16'h0000);
		idle();
		rd(10'h004, 16'h0000);
		key(16'h0040);
		key(16'h0000);
		rd(10'h000, 16'h0000);
		wr(10'h104, 16'h0102);
		idle();
		rd(10'h104, 16'h0102);
		key(16'h0040);
		rd(10'h000, 16'h0040);
		// Looked at mid-cycle, away from the edge that could launch it
		@(negedge clk);
		`CHK("mismatch", 1'b0, mismatch)
		@(posedge clk);
	endtask

	// Hang guard, far above the fewer than one hundred cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_route();
		t_lock();
		t_multi();
		print_verdict();
	end
endmodule

`default_nettype wire
